// File: hdl/cvs_top.sv
/*
 * Comparator output synchroniser, timer gate select and comparator
 * reference control, with registers on an AXI4-Lite slave.
 * Assumes one clock aclk, a synchronous active-low reset, and that the
 * prescaled timer clock, comparator outputs and gate pin arrive
 * asynchronously from outside the aclk domain.
 */
// What this block does
// - Latch comparator on timer clock falling edge.
// - Latch uses prescaled timer clock.
// - Timer counts rising, latch updates falling.
// - Bit 0 selects latched or asynchronous output.
// - Bit 1 selects gate pin; resets one.
// - Two-comparator variant gates second comparator only.
// - Sync register bits 7-2 read zero.
// - Enable powers ladder; off grounds reference.
// - Reference ignores comparator mode.
// - Range bit one selects low range.
// - Level gives n/24 or 1/4+n/32.
// - Reference register bits 6 and 4 read zero.
`default_nettype none
`include "cvs_cfg.svh"

module cvs_top #(
   parameter int ADDR_W  = 4,
   parameter bit TWO_CMP = 1'b1
) (
   // Clock and reset.
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // AXI4-Lite write address.
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   // AXI4-Lite write data.
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   // AXI4-Lite write response.
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   // AXI4-Lite read address.
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   // AXI4-Lite read data.
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   // Analog core and pins.
   input  wire logic              cmp1_out,
   input  wire logic              cmp2_out,
   input  wire logic              timer_clk_prescaled,
   input  wire logic              external_gate_pin,
   // Toward the gated timer.
   output logic                   timer_gate,
   output logic                   timer_tick,
   output logic                   comparator_sync_out,
   // Toward the reference ladder.
   output logic                   reference_power,
   output logic [6:0]             comparator_reference_voltage
);
   if (ADDR_W < 4) begin : g_addr_chk
      $error("ADDR_W must be at least 4");
   end

   // Pin synchronisers: bit 0 cmp1, 1 cmp2, 2 timer clock, 3 gate pin.
   logic [3:0] pin_raw;
   logic [3:0] pin_meta_ff;
   logic [3:0] pin_sync_ff;

   assign pin_raw = {external_gate_pin, timer_clk_prescaled, cmp2_out, cmp1_out};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_meta_ff <= 4'h0;
         pin_sync_ff <= 4'h0;
      end else begin
         pin_meta_ff <= pin_raw;
         pin_sync_ff <= pin_meta_ff;
      end
   end

   // Only the second comparator reaches the gate on the two-comparator part.
   logic gate_cmp;
   assign gate_cmp = TWO_CMP ? pin_sync_ff[1] : pin_sync_ff[0];

   // Registers.
   logic [7:0] sync_reg_ff;
   logic [7:0] vref_reg_ff;

   // Write channel state.
   logic [ADDR_W-1:0] wr_addr_ff;
   logic [7:0]        wr_data_ff;
   logic              wr_lane_ff;
   logic              aw_ready_ff;
   logic              w_ready_ff;
   logic              b_valid_ff;
   logic [1:0]        b_resp_ff;
   logic              wr_go;
   logic              wr_hit_sync;
   logic              wr_hit_vref;
   logic              wr_hit_stat;

   assign wr_go       = !aw_ready_ff && !w_ready_ff && !b_valid_ff;
   assign wr_hit_sync = wr_addr_ff[3:0] == `CVS_SYNC_OFS && (wr_addr_ff >> 4) == '0;
   assign wr_hit_vref = wr_addr_ff[3:0] == `CVS_VREF_OFS && (wr_addr_ff >> 4) == '0;
   assign wr_hit_stat = wr_addr_ff[3:0] == `CVS_STAT_OFS && (wr_addr_ff >> 4) == '0;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_ready_ff <= 1'b1;
         wr_addr_ff  <= '0;
      end else if (awvalid && aw_ready_ff) begin
         aw_ready_ff <= 1'b0;
         wr_addr_ff  <= awaddr;
      end else if (b_valid_ff && bready) begin
         aw_ready_ff <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_ready_ff <= 1'b1;
         wr_data_ff <= 8'h00;
         wr_lane_ff <= 1'b0;
      end else if (wvalid && w_ready_ff) begin
         w_ready_ff <= 1'b0;
         wr_data_ff <= wdata[7:0];
         wr_lane_ff <= wstrb[0];
      end else if (b_valid_ff && bready) begin
         w_ready_ff <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         b_valid_ff <= 1'b0;
         b_resp_ff  <= `CVS_RESP_OKAY;
      end else if (wr_go) begin
         b_valid_ff <= 1'b1;
         if (wr_hit_sync || wr_hit_vref || wr_hit_stat) b_resp_ff <= `CVS_RESP_OKAY;
         else b_resp_ff <= `CVS_RESP_SLVERR;
      end else if (b_valid_ff && bready) begin
         b_valid_ff <= 1'b0;
      end
   end

   // Unimplemented bits are masked so they never hold a one.
   always_ff @(posedge aclk) begin
      if (!aresetn) sync_reg_ff <= `CVS_SYNC_RST;
      else if (wr_go && wr_hit_sync && wr_lane_ff)
         sync_reg_ff <= wr_data_ff & `CVS_SYNC_MASK;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) vref_reg_ff <= `CVS_VREF_RST;
      else if (wr_go && wr_hit_vref && wr_lane_ff)
         vref_reg_ff <= wr_data_ff & `CVS_VREF_MASK;
   end

   // Synchroniser and gate mux.
   logic latched;
   logic path;
   logic gate;
   logic tick;

   cvs_sync_gate u_sync_gate (
      .aclk         (aclk),
      .aresetn      (aresetn),
      .tclk_s       (pin_sync_ff[2]),
      .cmp_s        (gate_cmp),
      .ext_s        (pin_sync_ff[3]),
      .sync_en      (sync_reg_ff[`CVS_SYNC_BIT]),
      .gate_pin_sel (sync_reg_ff[`CVS_GSEL_BIT]),
      .latched_ff   (latched),
      .path_ff      (path),
      .gate_ff      (gate),
      .tick_ff      (tick)
   );

   // Reference ladder.
   logic       vr_power;
   logic [6:0] vr_ratio;

   cvs_vref_tap u_vref_tap (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .enable    (vref_reg_ff[`CVS_REFERENCE_ENABLE_BIT]),
      .range_low (vref_reg_ff[`CVS_VRR_BIT]),
      .level     (vref_reg_ff[`CVS_VLVL_LSB +: 4]),
      .power_ff  (vr_power),
      .ratio_ff  (vr_ratio)
   );

   assign timer_gate                   = gate;
   assign timer_tick                   = tick;
   assign comparator_sync_out          = path;
   assign reference_power              = vr_power;
   assign comparator_reference_voltage = vr_ratio;

   // Read channel.
   logic              ar_ready_ff;
   logic              r_valid_ff;
   logic [31:0]       r_data_ff;
   logic [1:0]        r_resp_ff;
   cvs_pkg::cvs_reg_t rd_sel;
   logic [7:0]        stat_val;

   always_comb begin
      if ((araddr >> 4) != '0) rd_sel = cvs_pkg::CVS_REG_NONE;
      else if (araddr[3:0] == `CVS_SYNC_OFS) rd_sel = cvs_pkg::CVS_REG_SYNC;
      else if (araddr[3:0] == `CVS_VREF_OFS) rd_sel = cvs_pkg::CVS_REG_VREF;
      else if (araddr[3:0] == `CVS_STAT_OFS) rd_sel = cvs_pkg::CVS_REG_STAT;
      else rd_sel = cvs_pkg::CVS_REG_NONE;
   end

   always_comb begin
      stat_val                    = 8'h00;
      stat_val[`CVS_ST_PATH_BIT]  = path;
      stat_val[`CVS_ST_LATCH_BIT] = latched;
      stat_val[`CVS_ST_GATE_BIT]  = gate;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ar_ready_ff <= 1'b1;
         r_valid_ff  <= 1'b0;
         r_data_ff   <= 32'h0000_0000;
         r_resp_ff   <= `CVS_RESP_OKAY;
      end else if (arvalid && ar_ready_ff) begin
         ar_ready_ff <= 1'b0;
         r_valid_ff  <= 1'b1;
         r_resp_ff   <= `CVS_RESP_OKAY;
         case (rd_sel)
            cvs_pkg::CVS_REG_SYNC: r_data_ff <= {24'h00_0000, sync_reg_ff};
            cvs_pkg::CVS_REG_VREF: r_data_ff <= {24'h00_0000, vref_reg_ff};
            cvs_pkg::CVS_REG_STAT: r_data_ff <= {24'h00_0000, stat_val};
            default: begin
               r_data_ff <= 32'h0000_0000;
               r_resp_ff <= `CVS_RESP_SLVERR;
            end
         endcase
      end else if (r_valid_ff && rready) begin
         ar_ready_ff <= 1'b1;
         r_valid_ff  <= 1'b0;
      end
   end

   assign awready = aw_ready_ff;
   assign wready  = w_ready_ff;
   assign bvalid  = b_valid_ff;
   assign bresp   = b_resp_ff;
   assign arready = ar_ready_ff;
   assign rvalid  = r_valid_ff;
   assign rdata   = r_data_ff;
   assign rresp   = r_resp_ff;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_wr_taken;
      !aw_ready_ff && !w_ready_ff && !b_valid_ff;
   endsequence

   sequence s_resp_held;
      b_valid_ff ##1 (b_valid_ff || aw_ready_ff);
   endsequence

   sequence s_wr_done;
      b_valid_ff && bready;
   endsequence

   sequence s_rd_done;
      r_valid_ff && rready;
   endsequence

   reset_values_a: assert property ($past(!aresetn) |-> sync_reg_ff == 8'h02 && vref_reg_ff == 8'h00)
      else $error("register reset value wrong");
   sync_unimpl_a: assert property (sync_reg_ff[7:2] == 6'h00)
      else $error("sync register unimplemented bits set");
   vref_unimpl_a: assert property (!vref_reg_ff[6] && !vref_reg_ff[4])
      else $error("reference register unimplemented bits set");
   sync_read_zero_a: assert property (arvalid && ar_ready_ff && rd_sel == cvs_pkg::CVS_REG_SYNC
      |=> r_valid_ff && r_data_ff[31:2] == 30'h0)
      else $error("sync read upper bits not zero");
   gate_source_a: assert property (TWO_CMP && sync_reg_ff[1:0] == 2'h0
      && pin_sync_ff[0] != pin_sync_ff[1] |=> timer_gate != $past(pin_sync_ff[0]))
      else $error("first comparator reached the gate");
   second_cmp_a: assert property (TWO_CMP && !sync_reg_ff[0] && !sync_reg_ff[1]
      |=> timer_gate == $past(pin_sync_ff[1]))
      else $error("gate not following second comparator");
   write_resp_a: assert property (s_wr_taken |=> s_resp_held)
      else $error("write response missing");
   tick_edge_a: assert property ($rose(pin_sync_ff[2]) |=> timer_tick ##1 !timer_tick)
      else $error("tick not one cycle on rising edge");
   latch_fall_a: assert property ($fell(pin_sync_ff[2]) |=> ##1 (comparator_sync_out
      == latched || !$past(sync_reg_ff[0])))
      else $error("latched path not used");

   // Bus answers stand until taken, then the channel reopens.
   resp_stand_a: assert property (b_valid_ff && !bready |=> b_valid_ff && $stable(b_resp_ff))
      else $error("write response dropped");
   read_stand_a: assert property (r_valid_ff && !rready |=> r_valid_ff && $stable(r_data_ff))
      else $error("read data dropped");
   wr_reopen_a: assert property (s_wr_done |=> aw_ready_ff && w_ready_ff && !b_valid_ff)
      else $error("write channel not reopened");
   rd_reopen_a: assert property (s_rd_done |=> ar_ready_ff && !r_valid_ff)
      else $error("read channel not reopened");
   vref_read_zero_a: assert property (arvalid && ar_ready_ff
      && rd_sel == cvs_pkg::CVS_REG_VREF
      |=> !r_data_ff[6] && !r_data_ff[4] && r_data_ff[31:8] == 24'h0)
      else $error("reference read unimplemented bits set");

   // Timer side outputs follow the selected sources one edge later.
   sync_path_a: assert property (sync_reg_ff[0] |=> comparator_sync_out == $past(latched))
      else $error("synchronised output not latched");
   async_path_a: assert property (!sync_reg_ff[0]
      |=> comparator_sync_out == $past(gate_cmp))
      else $error("asynchronous output wrong");
   gate_pin_out_a: assert property (sync_reg_ff[1]
      |=> timer_gate == $past(pin_sync_ff[3]))
      else $error("gate not following pin");
   tick_quiet_a: assert property (!$rose(pin_sync_ff[2]) |=> !timer_tick)
      else $error("tick without rising edge");

   // Reference outputs follow the register one edge later.
   ref_power_a: assert property (vref_reg_ff[7] |=> reference_power)
      else $error("ladder not powered");
   ref_ground_a: assert property (!vref_reg_ff[7]
      |=> comparator_reference_voltage == 7'h00)
      else $error("reference not grounded");
   low_tap_a: assert property (vref_reg_ff[7] && vref_reg_ff[5]
      |=> comparator_reference_voltage == 7'($past(vref_reg_ff[3:0]) * 4))
      else $error("low range output wrong");
   high_tap_a: assert property (vref_reg_ff[7] && !vref_reg_ff[5]
      |=> comparator_reference_voltage == 7'(24 + $past(vref_reg_ff[3:0]) * 3))
      else $error("high range output wrong");
endmodule // cvs_top

`default_nettype wire

// File: hdl/cvs_cfg.svh
/*
 * Constants of the comparator sync and reference control block: register
 * offsets, field positions, reset values and ladder tap arithmetic.
 * Assumes it is included by the design files that need these values.
 */
`ifndef CVS_CFG_SVH
`define CVS_CFG_SVH

// Register byte offsets on the AXI4-Lite port.
`define CVS_SYNC_OFS     4'h0
`define CVS_VREF_OFS     4'h4
`define CVS_STAT_OFS     4'h8

// Sync and gate select register.
`define CVS_SYNC_BIT     0
`define CVS_GSEL_BIT     1
`define CVS_SYNC_RST     8'h02
`define CVS_SYNC_MASK    8'h03

// Voltage reference control register.
`define CVS_REFERENCE_ENABLE_BIT     7
`define CVS_VRR_BIT      5
`define CVS_VLVL_LSB     0
`define CVS_VREF_RST     8'h00
`define CVS_VREF_MASK    8'hAF

// Status register fields.
`define CVS_ST_PATH_BIT  0
`define CVS_ST_LATCH_BIT 1
`define CVS_ST_GATE_BIT  2

// Tap ratio in 96ths of the ladder supply.
`define CVS_LOW_STEP     7'h04
`define CVS_HIGH_BASE    7'h18
`define CVS_HIGH_STEP    7'h03

// AXI responses.
`define CVS_RESP_OKAY    2'h0
`define CVS_RESP_SLVERR  2'h2

`endif

// File: hdl/cvs_pkg.sv
/*
 * Types shared by the comparator sync and reference control block.
 * Assumes nothing of its surroundings.
 */
`default_nettype none

package cvs_pkg;

   // Read address decode result.
   typedef enum logic [1:0] {
      CVS_REG_SYNC,
      CVS_REG_VREF,
      CVS_REG_STAT,
      CVS_REG_NONE
   } cvs_reg_t;

endpackage

`default_nettype wire

// File: hdl/cvs_sync_gate.sv
/*
 * Comparator output latch on the falling edge of the prescaled timer clock,
 * and the timer gate source mux. Assumes all inputs are already
 * synchronised to aclk.
 */
`default_nettype none

module cvs_sync_gate (
   // Clock and reset.
   input  wire logic aclk,
   input  wire logic aresetn,
   // Synchronised inputs.
   input  wire logic tclk_s,
   input  wire logic cmp_s,
   input  wire logic ext_s,
   // Control.
   input  wire logic sync_en,
   input  wire logic gate_pin_sel,
   // Results.
   output logic      latched_ff,
   output logic      path_ff,
   output logic      gate_ff,
   output logic      tick_ff
);
   logic tclk_d_ff;
   logic fall_evt;
   logic rise_evt;
   logic nxt_path;

   assign fall_evt = tclk_d_ff & ~tclk_s;
   assign rise_evt = ~tclk_d_ff & tclk_s;
   assign nxt_path = sync_en ? latched_ff : cmp_s;

   always_ff @(posedge aclk) begin
      if (!aresetn) tclk_d_ff <= 1'b0;
      else tclk_d_ff <= tclk_s;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) latched_ff <= 1'b0;
      else if (fall_evt) latched_ff <= cmp_s;
   end

   // Counter tick on the opposite edge to the latch.
   always_ff @(posedge aclk) begin
      if (!aresetn) tick_ff <= 1'b0;
      else tick_ff <= rise_evt;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         path_ff <= 1'b0;
         gate_ff <= 1'b1;
      end else begin
         path_ff <= nxt_path;
         gate_ff <= gate_pin_sel ? ext_s : nxt_path;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   latch_on_fall_a: assert property (fall_evt |=> latched_ff == $past(cmp_s))
      else $error("latch missed falling edge");
   latch_hold_a: assert property (!fall_evt |=> $stable(latched_ff))
      else $error("latch moved off falling edge");
   async_pass_a: assert property (!sync_en && !gate_pin_sel |=> gate_ff == $past(cmp_s))
      else $error("async path wrong");
   pin_gate_a: assert property (gate_pin_sel |=> gate_ff == $past(ext_s))
      else $error("pin gate wrong");
endmodule // cvs_sync_gate

`default_nettype wire

// File: hdl/cvs_vref_tap.sv
/*
 * Reference ladder tap selection: power, range and level to a tap ratio
 * in 96ths of the ladder supply. Assumes register inputs on aclk.
 */
`default_nettype none
`include "cvs_cfg.svh"

module cvs_vref_tap (
   // Clock and reset.
   input  wire logic       aclk,
   input  wire logic       aresetn,
   // Control.
   input  wire logic       enable,
   input  wire logic       range_low,
   input  wire logic [3:0] level,
   // Ladder drive.
   output logic            power_ff,
   output logic [6:0]      ratio_ff
);
   logic [6:0] lvl7;
   assign lvl7 = {3'h0, level};

   // Independent of the comparator mode: nothing else feeds this path.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         power_ff <= 1'b0;
         ratio_ff <= 7'h00;
      end else begin
         power_ff <= enable;
         if (!enable) ratio_ff <= 7'h00;
         else if (range_low) ratio_ff <= 7'(lvl7 * `CVS_LOW_STEP);
         else ratio_ff <= 7'(`CVS_HIGH_BASE + lvl7 * `CVS_HIGH_STEP);
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   off_ground_a: assert property (!enable |=> !power_ff && ratio_ff == 7'h00)
      else $error("disabled ladder not grounded");
   low_range_a: assert property (enable && range_low |=> ratio_ff == 7'($past(lvl7) * 4))
      else $error("low range tap wrong");
   high_range_a: assert property (enable && !range_low |=> ratio_ff == 7'(24 + $past(lvl7) * 3))
      else $error("high range tap wrong");
endmodule // cvs_vref_tap

`default_nettype wire

// File: test/cvs_timer_model.sv
/*
 * Far-side model: prescaled timer clock, comparator outputs, gate pin and a
 * gated timer that counts ticks.
 * Assumes the bench commands the analog levels and reads the count.
 */
`default_nettype none

module cvs_timer_model #(
   parameter int TPER = 32
) (
   // Clock and reset.
   input  wire logic   aclk,
   input  wire logic   aresetn,
   // Levels commanded by the bench.
   input  wire logic   cmp1_lvl,
   input  wire logic   cmp2_lvl,
   input  wire logic   pin_lvl,
   input  wire logic   cnt_clr,
   // Pins toward the block.
   output logic        cmp1_out,
   output logic        cmp2_out,
   output logic        timer_clk_prescaled,
   output logic        external_gate_pin,
   // From the block.
   input  wire logic   timer_gate,
   input  wire logic   timer_tick,
   output logic [15:0] count_ff
);
   timeunit 1ns;
   timeprecision 100ps;

   int div_ff = 0;

   // The prescaler output runs free, as a timer clock source does.
   always_ff @(posedge aclk) begin
      div_ff <= (div_ff == TPER - 1) ? 0 : div_ff + 1;
      timer_clk_prescaled <= (div_ff < TPER / 2);
   end

   always_ff @(posedge aclk) begin
      cmp1_out <= cmp1_lvl;
      cmp2_out <= cmp2_lvl;
      external_gate_pin <= pin_lvl;
   end

   // The timer is taken as switched on with gating enabled.
   always_ff @(posedge aclk) begin
      if (!aresetn || cnt_clr) begin
         count_ff <= 16'h0000;
      end else if (timer_gate && timer_tick) begin
         count_ff <= count_ff + 16'h0001;
      end
   end
endmodule // cvs_timer_model

`default_nettype wire

// File: test/comparator_sync_vref_ctrl_tb.sv
/*
 * Self-checking bench for the comparator sync and reference block.
 * Assumes the far-side model drives the pins and counts timer ticks.
 */
`default_nettype none

module comparator_sync_vref_ctrl_tb;
   timeunit 1ns;
   timeprecision 100ps;

   logic aclk = 1'b0, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, cmp1_out, cmp2_out, tclk, ext_pin;
   logic timer_gate, timer_tick, sync_out, ref_pwr, cmp1_lvl, cmp2_lvl, pin_lvl, clr;
   logic [3:0]  awaddr, araddr, wstrb;
   logic [31:0] wdata, rdata;
   logic [1:0]  bresp, rresp;
   logic [6:0]  ref_v;
   logic [15:0] count;
   int errors = 0;
   int tests_run = 0;

   always #12.5 aclk = ~aclk;

   cvs_top #(.ADDR_W(4), .TWO_CMP(1'b1)) cvs_top_i (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready), .cmp1_out(cmp1_out),
      .cmp2_out(cmp2_out), .timer_clk_prescaled(tclk), .external_gate_pin(ext_pin),
      .timer_gate(timer_gate), .timer_tick(timer_tick), .comparator_sync_out(sync_out),
      .reference_power(ref_pwr), .comparator_reference_voltage(ref_v));

   cvs_timer_model #(.TPER(32)) cvs_timer_model_i (
      .aclk(aclk), .aresetn(aresetn), .cmp1_lvl(cmp1_lvl), .cmp2_lvl(cmp2_lvl),
      .pin_lvl(pin_lvl), .cnt_clr(clr), .cmp1_out(cmp1_out), .cmp2_out(cmp2_out),
      .timer_clk_prescaled(tclk), .external_gate_pin(ext_pin),
      .timer_gate(timer_gate), .timer_tick(timer_tick), .count_ff(count));

   task automatic report_and_stop();
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic hang(input string what);
      errors++;
      $display("unexpected at %0t: %s timed out", $time, what);
      report_and_stop();
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge aclk);
   endtask

   // Handshakes are judged at the falling edge, where the values of the
   // coming rising edge already stand.
   task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ta, tw, tb;
      logic [1:0] resp;
      @(posedge aclk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (int n = 0; n < 40; n++) begin
         @(negedge aclk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         tb = bvalid;
         resp = bresp;
         @(posedge aclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tb) begin
            bready <= 1'b0;
            chk({30'h0, resp}, {30'h0, er}, "write response");
            return;
         end
      end
      hang("write");
   endtask

   task automatic axi_read(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic ta, tr;
      logic [1:0] resp;
      logic [31:0] d;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (int n = 0; n < 40; n++) begin
         @(negedge aclk);
         ta = arvalid && arready;
         tr = rvalid;
         resp = rresp;
         d = rdata;
         @(posedge aclk);
         if (ta) arvalid <= 1'b0;
         if (tr) begin
            rready <= 1'b0;
            chk({30'h0, resp}, {30'h0, er}, "read response");
            chk(d, ed, "read data");
            return;
         end
      end
      hang("read");
   endtask

   task automatic wait_tclk(input logic lvl);
      for (int n = 0; n < 100; n++) begin
         @(posedge aclk);
         if (tclk === lvl) return;
      end
      hang("timer clock");
   endtask

   task automatic t_reset();
      axi_read(4'h0, 32'h0000_0002, 2'h0);
      axi_read(4'h4, 32'h0000_0000, 2'h0);
      chk({31'h0, timer_gate}, 32'h0000_0001, "gate after reset");
      chk({25'h0, ref_v}, 32'h0000_0000, "reference after reset");
   endtask

   task automatic t_reserved();
      axi_write(4'h0, 32'h0000_00FF, 2'h0);
      axi_read(4'h0, 32'h0000_0003, 2'h0);
      axi_write(4'h4, 32'h0000_00FF, 2'h0);
      axi_read(4'h4, 32'h0000_00AF, 2'h0);
      axi_write(4'hC, 32'h0000_0000, 2'h2);
      axi_read(4'hC, 32'h0000_0000, 2'h2);
      wstrb <= 4'h0;
      axi_write(4'h0, 32'h0000_0000, 2'h0);
      wstrb <= 4'hF;
      axi_read(4'h0, 32'h0000_0003, 2'h0);
   endtask

   task automatic t_ladder();
      logic [6:0] ev;
      for (int r = 0; r < 2; r++) begin
         for (int l = 0; l < 16; l++) begin
            ev = (r == 1) ? 7'(4 * l) : 7'(24 + 3 * l);
            axi_write(4'h4, 32'h0000_0080 | 32'(r << 5) | 32'(l), 2'h0);
            settle(4);
            chk({31'h0, ref_pwr}, 32'h0000_0001, "ladder power");
            chk({25'h0, ref_v}, {25'h0, ev}, "ladder tap");
         end
      end
      axi_write(4'h0, 32'h0000_0001, 2'h0);
      axi_read(4'h4, 32'h0000_00AF, 2'h0);
      axi_write(4'h4, 32'h0000_002F, 2'h0);
      settle(4);
      chk({31'h0, ref_pwr}, 32'h0000_0000, "ladder off");
      chk({25'h0, ref_v}, 32'h0000_0000, "grounded when off");
      axi_write(4'h4, 32'h0000_0020, 2'h0);
      settle(4);
      chk({25'h0, ref_v}, 32'h0000_0000, "clamped reference");
   endtask

   task automatic t_async();
      axi_write(4'h0, 32'h0000_0000, 2'h0);
      cmp2_lvl <= 1'b1;
      cmp1_lvl <= 1'b0;
      settle(8);
      chk({31'h0, sync_out}, 32'h0000_0001, "live output");
      chk({31'h0, timer_gate}, 32'h0000_0001, "comparator gate");
      cmp2_lvl <= 1'b0;
      cmp1_lvl <= 1'b1;
      settle(8);
      chk({31'h0, sync_out}, 32'h0000_0000, "live output low");
      chk({31'h0, timer_gate}, 32'h0000_0000, "comparator gate low");
   endtask

   task automatic t_latch();
      axi_write(4'h0, 32'h0000_0001, 2'h0);
      settle(70);
      wait_tclk(1'b0);
      wait_tclk(1'b1);
      cmp2_lvl <= 1'b1;
      cmp1_lvl <= 1'b0;
      settle(10);
      chk({31'h0, sync_out}, 32'h0000_0000, "held while clock high");
      chk({31'h0, timer_gate}, 32'h0000_0000, "gate held");
      wait_tclk(1'b0);
      settle(8);
      chk({31'h0, sync_out}, 32'h0000_0001, "latched at fall");
      chk({31'h0, timer_gate}, 32'h0000_0001, "gate from latch");
      axi_read(4'h8, 32'h0000_0007, 2'h0);
   endtask

   task automatic t_ticks();
      axi_write(4'h0, 32'h0000_0002, 2'h0);
      pin_lvl <= 1'b1;
      wait_tclk(1'b0);
      wait_tclk(1'b1);
      settle(16);
      clr <= 1'b1;
      settle(1);
      clr <= 1'b0;
      settle(128);
      chk({16'h0, count}, 32'h0000_0004, "one tick per timer clock");
      pin_lvl <= 1'b0;
      settle(8);
      chk({31'h0, timer_gate}, 32'h0000_0000, "pin gate low");
      clr <= 1'b1;
      settle(1);
      clr <= 1'b0;
      settle(128);
      chk({16'h0, count}, 32'h0000_0000, "no ticks while gated off");
   endtask

   task automatic t_rereset();
      axi_write(4'h0, 32'h0000_0001, 2'h0);
      axi_write(4'h4, 32'h0000_00A5, 2'h0);
      aresetn <= 1'b0;
      settle(2);
      aresetn <= 1'b1;
      axi_read(4'h0, 32'h0000_0002, 2'h0);
      axi_read(4'h4, 32'h0000_0000, 2'h0);
      chk({25'h0, ref_v}, 32'h0000_0000, "reference after second reset");
   endtask

   initial begin
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready, clr, cmp1_lvl, cmp2_lvl} = 8'h00;
      pin_lvl = 1'b1;
      awaddr = 4'h0;
      araddr = 4'h0;
      wdata = 32'h0000_0000;
      wstrb = 4'hF;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_reserved();
      t_ladder();
      t_async();
      t_latch();
      t_ticks();
      t_rereset();
      report_and_stop();
   end
endmodule // comparator_sync_vref_ctrl_tb

`default_nettype wire
